// file: hw/delay_timer.sv
// Loadable down-counter that flags the end of a programmed delay
module delay_timer #(
    parameter int unsigned W = 32
) (
    // Clock and control
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // Load
    input  wire logic         start_i,
    input  wire logic [W-1:0] cycles_i,
    // Status
    output logic              busy_o,
    output logic              done_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done_q;
    logic         done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (start_i) begin
            cnt_d = cycles_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
            done_d = (cnt_q == {{(W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (ce_i) begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy_o = (cnt_q != '0);
    assign done_o = done_q;

endmodule : delay_timer

// file: hw/reset_output_and_fault_recovery.sv
// Reset output generation and critical fault recovery sequencing
//////////////////////////////////////////////////////////////////////////////
module reset_output_and_fault_recovery
    import rst_seq_pkg::*;
#(
    parameter int unsigned N_CH           = 12,
    parameter int unsigned RETRY_CYC [8]  = rst_seq_pkg::RETRY_CYC_DEF,
    parameter int unsigned RESET_CYC [8]  = rst_seq_pkg::RESET_CYC_DEF
) (
    // Clock, reset, clock enable
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    // Register port
    input  wire logic [7:0]      reg_addr_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    input  wire logic [7:0]      reg_wdata_i,
    output logic      [7:0]      reg_rdata_o,
    // Enables
    input  wire logic            en_i,
    input  wire logic            sw_disable_i,
    // Monitor input comparisons, one result per conversion
    input  wire logic            conv_strobe_i,
    input  wire logic [N_CH-1:0] uv_raw_i,
    input  wire logic [N_CH-1:0] ov_raw_i,
    input  wire logic [N_CH-1:0] ew_raw_i,
    input  wire logic [N_CH-1:0] crit_en_i,
    input  wire logic [N_CH-1:0] ch_live_i,
    // Sequencer status
    input  wire logic [N_CH-1:0] last_slot_mask_i,
    input  wire logic            last_slot_delay_done_i,
    input  wire logic            seq_power_down_i,
    // Manual reset
    input  wire logic            general_pin_four_is_mr_i,
    input  wire logic            manual_reset_in_n_i,
    // Reset pad
    output logic                 reset_pin_o,
    output logic                 reset_pin_oe_o,
    output logic                 drive_open_drain_o,
    // Supply control
    output logic                 supply_enable_o,
    output logic                 force_off_o,
    output logic                 retry_wait_o,
    output logic [9:0]           slew_vps_o,
    // Fault log control
    output logic                 log_trigger_o,
    output logic                 log_lines_o,
    output logic                 log_adc_o
);

    import rst_seq_pkg::*;

    typedef enum logic [6:0] {
        ST_OFF    = 7'b0000001,
        ST_PWR_UP = 7'b0000010,
        ST_HOLD   = 7'b0000100,
        ST_RUN    = 7'b0001000,
        ST_RETRY  = 7'b0010000,
        ST_LATCH  = 7'b0100000,
        ST_PWR_DN = 7'b1000000
    } state_t;

    //////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]      out_cfg_q;
    logic [7:0]      out_cfg_d;
    logic [7:0]      dep_lo_q;
    logic [7:0]      dep_lo_d;
    logic [3:0]      dep_hi_q;
    logic [3:0]      dep_hi_d;
    logic [1:0]      log_ctl_q;
    logic [1:0]      log_ctl_d;
    logic [7:0]      rec_cfg_q;
    logic [7:0]      rec_cfg_d;
    logic [7:0]      rdata_q;
    logic [7:0]      rdata_d;
    logic [7:0]      status;
    state_t          state_q;
    state_t          state_d;

    always_comb begin
        out_cfg_d = out_cfg_q;
        dep_lo_d  = dep_lo_q;
        dep_hi_d  = dep_hi_q;
        log_ctl_d = log_ctl_q;
        rec_cfg_d = rec_cfg_q;
        rdata_d   = rdata_q;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                RESET_OUTPUT_CONFIG_OFF:   out_cfg_d = {1'b0, reg_wdata_i[6:0]};
                RESET_DEPENDENCY_LOW_OFF:  dep_lo_d = reg_wdata_i;
                RESET_DEPENDENCY_HIGH_OFF: dep_hi_d = reg_wdata_i[3:0];
                FAULT_LOG_CONTROL_OFF:     log_ctl_d = reg_wdata_i[1:0];
                FAULT_RECOVERY_CONFIG_OFF: rec_cfg_d = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                RESET_OUTPUT_CONFIG_OFF:   rdata_d = out_cfg_q;
                RESET_DEPENDENCY_LOW_OFF:  rdata_d = dep_lo_q;
                RESET_DEPENDENCY_HIGH_OFF: rdata_d = {4'h0, dep_hi_q};
                FAULT_LOG_CONTROL_OFF:     rdata_d = {6'h00, log_ctl_q};
                FAULT_RECOVERY_CONFIG_OFF: rdata_d = rec_cfg_q;
                BLOCK_STATUS_OFF:          rdata_d = status;
                default:                   rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_cfg_q <= RESET_OUTPUT_CONFIG_RST;
            dep_lo_q  <= RESET_DEPENDENCY_LOW_RST;
            dep_hi_q  <= RESET_DEPENDENCY_HIGH_RST;
            log_ctl_q <= FAULT_LOG_CONTROL_RST;
            rec_cfg_q <= FAULT_RECOVERY_CONFIG_RST;
            rdata_q   <= 8'h00;
        end else if (ce_i) begin
            out_cfg_q <= out_cfg_d;
            dep_lo_q  <= dep_lo_d;
            dep_hi_q  <= dep_hi_d;
            log_ctl_q <= log_ctl_d;
            rec_cfg_q <= rec_cfg_d;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    //////////////////////////////////////////////////////////////////////////
    // Fault deglitch, one counter per input and threshold

    logic [3*N_CH-1:0] raw_flat;
    logic [3*N_CH-1:0] conf_flat;
    logic [4:0]        need;
    logic [N_CH-1:0]   uv_c;
    logic [N_CH-1:0]   ov_c;
    logic [N_CH-1:0]   ew_c;

    assign need     = 5'(DEGLITCH_CONV[rec_cfg_q[DEGLITCH_LSB +: 2]]);
    assign raw_flat = {ew_raw_i, ov_raw_i, uv_raw_i};

    for (genvar g = 0; g < 3 * N_CH; g++) begin : g_deglitch
        logic [4:0] cnt_q;
        logic [4:0] cnt_d;

        // Saturates at the deepest setting so a code change never wraps
        always_comb begin
            cnt_d = cnt_q;
            if (conv_strobe_i) begin
                if (!raw_flat[g]) begin
                    cnt_d = 5'h00;
                end else if (cnt_q != 5'h10) begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cnt_q <= 5'h00;
            end else if (ce_i) begin
                cnt_q <= cnt_d;
            end
        end

        assign conf_flat[g] = (cnt_q >= need);
    end

    assign uv_c = conf_flat[N_CH-1:0];
    assign ov_c = conf_flat[2*N_CH-1:N_CH];
    assign ew_c = conf_flat[3*N_CH-1:2*N_CH];

    //////////////////////////////////////////////////////////////////////////
    // Reset conditions

    logic [11:0]     dep_all;
    logic [N_CH-1:0] sel;
    logic [N_CH-1:0] hit;
    logic            manual_rst;
    logic            cond;
    logic            enabled;
    logic            seq_done;
    logic            crit_fault;
    logic            seq_fault;

    assign dep_all = {dep_hi_q, dep_lo_q};
    assign sel = dep_all[N_CH-1:0] | crit_en_i;

    always_comb begin
        unique case (out_cfg_q[COND_LSB +: 2])
            COND_UV:    hit = uv_c;
            COND_EW:    hit = ew_c;
            COND_OV:    hit = ov_c;
            COND_UV_OV: hit = uv_c | ov_c;
        endcase
    end

    // manual reset when pin four is set as manual reset input and is low
    assign manual_rst = general_pin_four_is_mr_i & ~manual_reset_in_n_i;
    assign cond       = manual_rst | (|(sel & hit));
    assign enabled    = en_i & ~sw_disable_i;

    // empty last slot waits for its delay
    assign seq_done = (|last_slot_mask_i) ? &(~uv_raw_i | ~last_slot_mask_i)
                                          : last_slot_delay_done_i;

    assign crit_fault = |(crit_en_i & (uv_c | ov_c));
    // any live rail, whatever the critical enables
    assign seq_fault  = |(ch_live_i & (uv_c | ov_c));

    //////////////////////////////////////////////////////////////////////////
    // Sequencing state machine

    logic        tmr_start;
    logic [31:0] tmr_cycles;
    logic        tmr_done;
    logic        shutdown;
    logic        force_off_q;
    logic        force_off_d;
    logic        trig_q;
    logic        trig_d;
    logic        rst_act_q;
    logic        rst_act_d;

    always_comb begin
        state_d    = state_q;
        tmr_start  = 1'b0;
        tmr_cycles = RESET_CYC[out_cfg_q[TMO_LSB +: 3]];
        shutdown   = 1'b0;
        unique case (state_q)
            ST_OFF: begin
                if (enabled) begin
                    state_d = ST_PWR_UP;
                end
            end
            ST_PWR_UP: begin
                if (!enabled) begin
                    state_d = ST_PWR_DN;
                end else if (seq_fault) begin
                    shutdown = 1'b1;
                end else if (seq_done) begin
                    state_d   = ST_HOLD;
                    tmr_start = 1'b1;
                end
            end
            ST_HOLD: begin
                if (!enabled) begin
                    state_d = ST_PWR_DN;
                end else if (crit_fault) begin
                    shutdown = 1'b1;
                end else if (cond) begin
                    tmr_start = 1'b1;
                end else if (tmr_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!enabled) begin
                    state_d = ST_PWR_DN;
                end else if (crit_fault) begin
                    shutdown = 1'b1;
                end else if (cond) begin
                    state_d   = ST_HOLD;
                    tmr_start = 1'b1;
                end
            end
            ST_RETRY: begin
                if (!enabled) begin
                    state_d = ST_OFF;
                end else if (tmr_done) begin
                    state_d = ST_PWR_UP;
                end
            end
            ST_LATCH: begin
                // only an enable toggle leaves latch-off
                if (!enabled) begin
                    state_d = ST_OFF;
                end
            end
            ST_PWR_DN: begin
                if (!seq_power_down_i) begin
                    state_d = ST_OFF;
                end
            end
            default: state_d = ST_OFF;
        endcase
        if (shutdown) begin
            if (rec_cfg_q[LATCH_BIT]) begin
                state_d = ST_LATCH;
            end else begin
                state_d    = ST_RETRY;
                tmr_start  = 1'b1;
                tmr_cycles = RETRY_CYC[rec_cfg_q[RETRY_LSB +: 3]];
            end
        end
        // hard stop of every supply enable
        force_off_d = (state_d == ST_RETRY) || (state_d == ST_LATCH)
                      || ((state_q == ST_PWR_DN) && seq_fault);
        // log only when something is stored
        trig_d      = shutdown && (log_ctl_q != LOG_NOTHING);
        // asserted in every state but running
        rst_act_d   = (state_d != ST_RUN);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= ST_OFF;
            force_off_q <= 1'b0;
            trig_q      <= 1'b0;
            rst_act_q   <= 1'b1;
        end else if (ce_i) begin
            state_q     <= state_d;
            force_off_q <= force_off_d;
            trig_q      <= trig_d;
            rst_act_q   <= rst_act_d;
        end
    end

    // Shared timer: hold timeout and retry wait never overlap
    delay_timer #(
        .W        (32)
    ) u_timer (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .start_i  (tmr_start),
        .cycles_i (tmr_cycles),
        .busy_o   (),
        .done_o   (tmr_done)
    );

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    logic pin_level;

    assign pin_level = out_cfg_q[POLARITY_BIT] ? rst_act_q : ~rst_act_q;

    assign drive_open_drain_o = out_cfg_q[OPEN_DRN_BIT];
    assign reset_pin_o        = out_cfg_q[OPEN_DRN_BIT] ? 1'b0 : pin_level;
    assign reset_pin_oe_o     = out_cfg_q[OPEN_DRN_BIT] ? ~pin_level : 1'b1;

    assign supply_enable_o = (state_q == ST_PWR_UP) || (state_q == ST_HOLD)
                             || (state_q == ST_RUN);
    assign force_off_o     = force_off_q;
    assign retry_wait_o    = (state_q == ST_RETRY);
    // ramp rate from the slew code
    assign slew_vps_o      = 10'(SLEW_VPS[rec_cfg_q[SLEW_LSB +: 2]]);
    assign log_trigger_o   = trig_q;
    assign log_lines_o     = ~log_ctl_q[1];
    assign log_adc_o       = ~log_ctl_q[0];

    assign status = {1'b0, state_q == ST_PWR_DN, state_q == ST_LATCH,
                     state_q == ST_RETRY, state_q == ST_RUN, state_q == ST_HOLD,
                     state_q == ST_PWR_UP, rst_act_q};

endmodule : reset_output_and_fault_recovery

// file: hw/rst_seq_pkg.sv
// Shared constants for the reset output and fault recovery block
package rst_seq_pkg;

    // Clock rate
    localparam int unsigned CLK_MHZ = 200;

    // Register offsets
    localparam logic [7:0] RESET_OUTPUT_CONFIG_OFF   = 8'h19;
    localparam logic [7:0] RESET_DEPENDENCY_LOW_OFF  = 8'h1A;
    localparam logic [7:0] RESET_DEPENDENCY_HIGH_OFF = 8'h1B;
    localparam logic [7:0] FAULT_LOG_CONTROL_OFF     = 8'h47;
    localparam logic [7:0] FAULT_RECOVERY_CONFIG_OFF = 8'h4F;
    localparam logic [7:0] BLOCK_STATUS_OFF          = 8'h7F;

    // Reset values
    localparam logic [7:0] RESET_OUTPUT_CONFIG_RST   = 8'h00;
    localparam logic [7:0] RESET_DEPENDENCY_LOW_RST  = 8'h00;
    localparam logic [3:0] RESET_DEPENDENCY_HIGH_RST = 4'h0;
    localparam logic [1:0] FAULT_LOG_CONTROL_RST     = 2'h0;
    localparam logic [7:0] FAULT_RECOVERY_CONFIG_RST = 8'h00;

    // Field positions in reset_output_config
    localparam int unsigned COND_LSB     = 0;
    localparam int unsigned POLARITY_BIT = 2;
    localparam int unsigned OPEN_DRN_BIT = 3;
    localparam int unsigned TMO_LSB      = 4;

    // Field positions in fault_recovery_config
    localparam int unsigned RETRY_LSB    = 0;
    localparam int unsigned LATCH_BIT    = 3;
    localparam int unsigned SLEW_LSB     = 4;
    localparam int unsigned DEGLITCH_LSB = 6;

    // Reset condition codes
    localparam logic [1:0] COND_UV    = 2'h0;
    localparam logic [1:0] COND_EW    = 2'h1;
    localparam logic [1:0] COND_OV    = 2'h2;
    localparam logic [1:0] COND_UV_OV = 2'h3;

    // Fault log code that stores nothing
    localparam logic [1:0] LOG_NOTHING = 2'h3;

    // Time tables in microseconds
    localparam int unsigned RETRY_DELAY_US [8] =
        '{20, 18750, 37500, 75000, 150000, 300000, 600000, 2400000};
    localparam int unsigned RESET_TIMEOUT_US [8] =
        '{25, 3000, 3750, 150000, 300000, 600000, 1200000, 2400000};

    // Ramp rates in V/s and deglitch depths in conversions
    localparam int unsigned SLEW_VPS [4]      = '{800, 400, 200, 100};
    localparam int unsigned DEGLITCH_CONV [4] = '{2, 4, 8, 16};

    function automatic int unsigned us_to_cyc(input int unsigned us);
        return us * CLK_MHZ;
    endfunction : us_to_cyc

    localparam int unsigned RETRY_CYC_DEF [8] = '{
        us_to_cyc(RETRY_DELAY_US[0]), us_to_cyc(RETRY_DELAY_US[1]),
        us_to_cyc(RETRY_DELAY_US[2]), us_to_cyc(RETRY_DELAY_US[3]),
        us_to_cyc(RETRY_DELAY_US[4]), us_to_cyc(RETRY_DELAY_US[5]),
        us_to_cyc(RETRY_DELAY_US[6]), us_to_cyc(RETRY_DELAY_US[7])};
    localparam int unsigned RESET_CYC_DEF [8] = '{
        us_to_cyc(RESET_TIMEOUT_US[0]), us_to_cyc(RESET_TIMEOUT_US[1]),
        us_to_cyc(RESET_TIMEOUT_US[2]), us_to_cyc(RESET_TIMEOUT_US[3]),
        us_to_cyc(RESET_TIMEOUT_US[4]), us_to_cyc(RESET_TIMEOUT_US[5]),
        us_to_cyc(RESET_TIMEOUT_US[6]), us_to_cyc(RESET_TIMEOUT_US[7])};

endpackage : rst_seq_pkg

// file: testbench/reset_output_props.sv
// Port checker for the reset output block, bound below
module reset_output_props
    import rst_seq_pkg::*;
#(
    parameter int unsigned RESET_CYC [8] = RESET_CYC_DEF
) (
    // Clock and register port
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    // Manual reset
    input wire logic       general_pin_four_is_mr_i,
    input wire logic       manual_reset_in_n_i,
    // Outputs
    input wire logic       reset_pin_o,
    input wire logic       reset_pin_oe_o,
    input wire logic       drive_open_drain_o,
    input wire logic [9:0] slew_vps_o,
    input wire logic       log_trigger_o,
    input wire logic       log_lines_o,
    input wire logic       log_adc_o
);
    localparam int unsigned MIN_HOLD = RESET_CYC[0] + 1;
    logic       pol_q;
    logic [7:0] run_q;
    logic       act;
    ////////////////////////////////////////////////////////////////////////
    // Pulled-up pad level against the shadowed polarity
    assign act = ((drive_open_drain_o ? ~reset_pin_oe_o : reset_pin_o) == pol_q);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pol_q <= 1'b0;
            run_q <= 8'h00;
        end else begin
            if (ce_i && reg_wr_i && reg_addr_i == RESET_OUTPUT_CONFIG_OFF) begin
                pol_q <= reg_wdata_i[POLARITY_BIT];
            end
            // Saturates so a long hold never wraps short
            run_q <= !act ? 8'h00 : (run_q == 8'hFF) ? run_q : run_q + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_wr(logic [7:0] a);
        ce_i && reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_pulse;
        (log_lines_o || log_adc_o) && log_trigger_o ##1 !log_trigger_o;
    endsequence
    chk_pp_drive: assert property (!drive_open_drain_o |-> reset_pin_oe_o)
        else $error("push-pull pad not driven");
    chk_od_data: assert property (drive_open_drain_o |-> !reset_pin_o)
        else $error("open-drain pad data high");
    chk_drive_bit: assert property (s_wr(RESET_OUTPUT_CONFIG_OFF) |=>
        drive_open_drain_o == $past(reg_wdata_i[OPEN_DRN_BIT]))
        else $error("drive mode not taken");
    chk_slew_code: assert property (s_wr(FAULT_RECOVERY_CONFIG_OFF) |=>
        slew_vps_o == 10'(SLEW_VPS[$past(reg_wdata_i[5:4])]))
        else $error("ramp rate wrong");
    chk_log_code: assert property (s_wr(FAULT_LOG_CONTROL_OFF) |=>
        {log_lines_o, log_adc_o} == ~$past(reg_wdata_i[1:0]))
        else $error("log selection wrong");
    chk_log_pulse: assert property (log_trigger_o |-> s_pulse)
        else $error("log trigger not a single pulse");
    chk_manual_rst: assert property (ce_i && general_pin_four_is_mr_i &&
        !manual_reset_in_n_i |=> act)
        else $error("manual reset not seen on pad");
    chk_release_wait: assert property ($fell(act) |-> run_q >= MIN_HOLD)
        else $error("reset released too early");
endmodule : reset_output_props
bind reset_output_and_fault_recovery reset_output_props #(.RESET_CYC(RESET_CYC)) u_props (.*);

// file: testbench/reset_receiver.sv
// Receiver of the reset pad, with pull-up and a push button
module reset_receiver (
    // Pad
    input  wire logic pin_i,
    input  wire logic oe_i,
    input  wire logic act_high_i,
    // Button
    input  wire logic press_i,
    // View
    output logic      active_o,
    output logic      manual_reset_in_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up reads a released pad high
    assign active_o = ((oe_i ? pin_i : 1'b1) == act_high_i);
    assign manual_reset_in_n_o = ~press_i;
endmodule : reset_receiver

// file: testbench/tb_reset_output_and_fault_recovery.sv
// Self-checking bench for the reset output block
module tb_reset_output_and_fault_recovery;
    timeunit 1ns;
    timeprecision 1ps;
    import rst_seq_pkg::*;
    typedef struct packed {
        logic [7:0]  cfg;
        logic [11:0] uv;
        logic [11:0] ov;
        logic [11:0] ew;
        logic        act;
    } row_t;
    localparam int unsigned RST_CYC [8] = '{4, 6, 8, 10, 12, 14, 16, 18};
    localparam int unsigned TRY_CYC [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
    localparam logic [23:0] REGS [4] = '{24'h19FF7F, 24'h1BFF0F, 24'h47FF03, 24'h55FF00};
    // Channel 0 and 11 are dependent, channel 1 is not
    localparam row_t ROWS [8] = '{
        '{8'h00, 12'h001, 12'h000, 12'h000, 1'b1},
        '{8'h00, 12'h000, 12'h001, 12'h000, 1'b0},
        '{8'h01, 12'h000, 12'h000, 12'h001, 1'b1},
        '{8'h02, 12'h000, 12'h800, 12'h000, 1'b1},
        '{8'h03, 12'h001, 12'h000, 12'h000, 1'b1},
        '{8'h03, 12'h002, 12'h000, 12'h000, 1'b0},
        '{8'h04, 12'h001, 12'h000, 12'h000, 1'b1},
        '{8'h08, 12'h800, 12'h000, 12'h000, 1'b1}};
    logic        clk_i, rst_i, ce_i, reg_wr_i, reg_rd_i, en_i, sw_disable_i;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [11:0] uv_raw_i, ov_raw_i, ew_raw_i, crit_en_i, ch_live_i, last_slot_mask_i;
    logic        conv_strobe_i, last_slot_delay_done_i, seq_power_down_i;
    logic        general_pin_four_is_mr_i, manual_reset_in_n_i, reset_pin_o;
    logic        reset_pin_oe_o, drive_open_drain_o, supply_enable_o, force_off_o;
    logic        retry_wait_o, log_trigger_o, log_lines_o, log_adc_o;
    logic        press, pol, active;
    logic [9:0]  slew_vps_o;
    int          miscompares, compares;
    reset_receiver u_rx (
        .pin_i               (reset_pin_o),
        .oe_i                (reset_pin_oe_o),
        .act_high_i          (pol),
        .press_i             (press),
        .active_o            (active),
        .manual_reset_in_n_o (manual_reset_in_n_i)
    );
    reset_output_and_fault_recovery #(
        .N_CH      (12),
        .RETRY_CYC (TRY_CYC),
        .RESET_CYC (RST_CYC)
    ) u_dut (.*);
    ////////////////////////////////////////////////////////////////////////
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) conv_strobe_i <= ~conv_strobe_i;
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask : rd
    // Bounded wait: 0 reset active, 1 retry wait, 2 supply enable
    task automatic wait_for(input int sel, input logic want);
        logic v;
        int   n;
        n = 0;
        v = ~want;
        while (v !== want && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
            v = (sel == 0) ? active : (sel == 1) ? retry_wait_o : supply_enable_o;
        end
        chk("wait target", {7'h0, want}, {7'h0, v});
        if (v !== want) finish_test();
    endtask : wait_for
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        int         n;
        {clk_i, reg_wr_i, reg_rd_i, press, pol, conv_strobe_i, en_i} = '0;
        {rst_i, ce_i, general_pin_four_is_mr_i} = '1;
        {sw_disable_i, last_slot_delay_done_i, seq_power_down_i} = '0;
        {reg_addr_i, reg_wdata_i} = '0;
        {uv_raw_i, ov_raw_i, ew_raw_i, crit_en_i, ch_live_i} = '0;
        last_slot_mask_i = 12'h004;
        miscompares = 0;
        compares = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("reset active", 8'h01, {7'h0, active});
        foreach (REGS[i]) begin
            rd(REGS[i][23:16], d);
            chk("reset value", 8'h00, d);
            wr(REGS[i][23:16], REGS[i][15:8]);
            rd(REGS[i][23:16], d);
            chk("readback", REGS[i][7:0], d);
        end
        wr(RESET_OUTPUT_CONFIG_OFF, 8'h00);
        wr(FAULT_LOG_CONTROL_OFF, 8'h01);
        wr(RESET_DEPENDENCY_LOW_OFF, 8'h01);
        wr(RESET_DEPENDENCY_HIGH_OFF, 8'h08);
        $display("test registers done");
        // Slot input still below its threshold
        uv_raw_i <= 12'h004;
        en_i     <= 1'b1;
        repeat (30) @(posedge clk_i);
        #1;
        chk("held for slot", 8'h01, {7'h0, active});
        @(posedge clk_i);
        uv_raw_i <= 12'h000;
        wait_for(0, 1'b0);
        last_slot_mask_i       <= 12'h000;
        last_slot_delay_done_i <= 1'b1;
        $display("test power-up done");
        foreach (ROWS[i]) begin
            wr(RESET_OUTPUT_CONFIG_OFF, ROWS[i].cfg);
            pol = ROWS[i].cfg[POLARITY_BIT];
            @(posedge clk_i);
            uv_raw_i <= ROWS[i].uv;
            ov_raw_i <= ROWS[i].ov;
            ew_raw_i <= ROWS[i].ew;
            repeat (12) @(posedge clk_i);
            #1;
            chk("fault reset", {7'h0, ROWS[i].act}, {7'h0, active});
            @(posedge clk_i);
            {uv_raw_i, ov_raw_i, ew_raw_i} <= '0;
            wait_for(0, 1'b0);
        end
        $display("test fault rows done");
        for (int c = 0; c < 8; c++) begin
            wr(RESET_OUTPUT_CONFIG_OFF, {1'b0, 3'(c), 4'h0});
            pol = 1'b0;
            press <= 1'b1;
            repeat (2) @(posedge clk_i);
            press <= 1'b0;
            n = 0;
            do begin
                @(posedge clk_i);
                #1;
                n++;
            end while (active !== 1'b0 && n < 40);
            chk("release delay", 8'(RST_CYC[c] + 1), 8'(n));
        end
        $display("test timeout codes done");
        wr(RESET_OUTPUT_CONFIG_OFF, 8'h00);
        wr(FAULT_RECOVERY_CONFIG_OFF, 8'hC0);
        uv_raw_i <= 12'h001;
        repeat (20) @(posedge clk_i);
        #1;
        chk("deglitch early", 8'h00, {7'h0, active});
        repeat (20) @(posedge clk_i);
        #1;
        chk("deglitch late", 8'h01, {7'h0, active});
        @(posedge clk_i);
        uv_raw_i <= 12'h000;
        wait_for(0, 1'b0);
        crit_en_i <= 12'h010;
        wr(FAULT_RECOVERY_CONFIG_OFF, 8'h00);
        uv_raw_i <= 12'h010;
        wait_for(1, 1'b1);
        chk("forced off", 8'h01, {7'h0, force_off_o});
        uv_raw_i <= 12'h000;
        wait_for(1, 1'b0);
        wait_for(0, 1'b0);
        $display("test autoretry done");
        wr(FAULT_RECOVERY_CONFIG_OFF, 8'h08);
        uv_raw_i <= 12'h010;
        wait_for(2, 1'b0);
        uv_raw_i               <= 12'h000;
        last_slot_delay_done_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        #1;
        chk("latched off", 8'h00, {7'h0, supply_enable_o});
        sw_disable_i <= 1'b1;
        @(posedge clk_i);
        sw_disable_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        #1;
        chk("slot delay pending", 8'h01, {7'h0, active});
        last_slot_delay_done_i <= 1'b1;
        wait_for(0, 1'b0);
        $display("test latch-off done");
        finish_test();
    end
endmodule : tb_reset_output_and_fault_recovery
